// ---- design/tsq_pkg.sv ----
package tsq_pkg;

  localparam int unsigned AW = 4;
  localparam int unsigned DW = 32;

  localparam int unsigned CLK_MHZ     = 250;
  localparam int unsigned QUARTER_NS  = 12;
  localparam int unsigned QUARTER_CYC = (QUARTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W       = 16;

  localparam logic [AW-1:0] OFS_CTRL = 4'h0;
  localparam logic [AW-1:0] OFS_STAT = 4'h4;
  localparam logic [AW-1:0] OFS_DATA = 4'h8;

  localparam int unsigned CTL_DONE  = 7;
  localparam int unsigned CTL_ACKEN = 6;
  localparam int unsigned CTL_BEGIN = 5;
  localparam int unsigned CTL_HALT  = 4;
  localparam int unsigned CTL_WCOL  = 3;
  localparam int unsigned CTL_EN    = 2;
  localparam int unsigned CTL_RSVD  = 1;
  localparam int unsigned CTL_IRQEN = 0;
  localparam int unsigned DIR_BIT   = 0;

  localparam logic [7:0] ST_START     = 8'h08;
  localparam logic [7:0] ST_RESTART   = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK  = 8'h18;
  localparam logic [7:0] ST_ADDR_NACK = 8'h20;
  localparam logic [7:0] ST_DATA_ACK  = 8'h28;
  localparam logic [7:0] ST_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST  = 8'h38;
  localparam logic [7:0] ST_RD_ACK    = 8'h40;
  localparam logic [7:0] ST_RD_NACK   = 8'h48;
  localparam logic [7:0] ST_NO_INFO   = 8'hF8;

  localparam logic [1:0] PH_SETUP  = 2'h0;
  localparam logic [1:0] PH_HIGH   = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LOW    = 2'h3;
  localparam logic [2:0] BIT_MSB   = 3'h7;
  localparam logic [2:0] BIT_LSB   = 3'h0;

  typedef enum logic [2:0] {S_IDLE, S_WAIT, S_START, S_BYTE, S_ACK, S_HOLD, S_STOP} tsq_state_t;

endpackage

// ---- design/tsq_line_if.sv ----
`timescale 1ns/1ps
interface tsq_line_if;
  logic sclLvl;
  logic sdaLvl;
  modport src (output sclLvl, output sdaLvl);
  modport dst (input sclLvl, input sdaLvl);
endinterface

// ---- design/tsq_line_sync.sv ----
`timescale 1ns/1ps
module tsq_line_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic sclRaw,
  input  wire logic sdaRaw,
  tsq_line_if.src   line
);
  import tsq_pkg::*;

  logic [1:0] rawIn;
  logic [1:0] meta_r;
  logic [1:0] sync_r;

  assign rawIn = {sdaRaw, sclRaw};

  // Idle wires float high, so both stages reset to one.
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        meta_r[i] <= 1'b1;
        sync_r[i] <= 1'b1;
      end else begin
        meta_r[i] <= rawIn[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign line.sclLvl = sync_r[0];
  assign line.sdaLvl = sync_r[1];
endmodule

// ---- design/tsq_tick_gen.sv ----
`timescale 1ns/1ps
module tsq_tick_gen #(
  parameter int unsigned PERIOD = tsq_pkg::QUARTER_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  import tsq_pkg::*;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
      tick  <= 1'b0;
    end
  end
endmodule

// ---- design/tsq_master_tx.sv ----
`timescale 1ns/1ps
// How it works
// RULE1: Software starts with done 1, begin 1, halt 0, enable 1, reserved 0.
// RULE2: A begin request waits until the bus is seen free before START.
// RULE3: After START the done flag rises with status 08.
// RULE4: Software loads address with write bit, then clears done with both requests 0.
// RULE5: After address and acknowledge, status is 18, 20 or 38.
// RULE6: Software writes the data register only while done is high.
// RULE7: A data write while done is low is dropped and sets write collision.
// RULE8: Clearing done with no requests sends the loaded byte; status 28 or 30.
// RULE9: Software requests STOP with done 1, begin 0, halt 1, enable 1.
// RULE10: Software requests repeated START with the same pattern as START.
// RULE11: After repeated START status is 10 and the bus stays owned.
// RULE12: Address with read bit switches to receiver operation; write bit stays transmitting.
// RULE13: In transmit states, clearing done with only begin sends repeated START.
// RULE14: Clearing done with only halt sends STOP and hardware clears halt.
// RULE15: Clearing done with begin and halt sends STOP, then START, clearing halt.
// RULE16: Lost arbitration reports 38; clearing with no requests releases bus, goes idle.
// RULE17: In state 38, clearing done with begin starts again once bus is free.
// RULE18: Software keeps enable at 1; acknowledge and interrupt enables are unused here.
// RULE19: While done is set the transfer is held suspended.
// RULE20: Software masks status with F8 before comparing codes.
// RULE21: Write direction enters transmit mode, read direction enters receive mode.
// RULE22: Direction bit is driven low for write and high for read.
// RULE23: Control bits downward: done, ack enable, begin, halt, collision, enable, reserved, irq.
module tsq_master_tx #(
  parameter int unsigned QUARTER = tsq_pkg::QUARTER_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [tsq_pkg::AW-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [tsq_pkg::DW-1:0] avs_writedata,
  output logic      [tsq_pkg::DW-1:0] avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   scl_i,
  output logic                        scl_o,
  output logic                        scl_oe,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe
);
  import tsq_pkg::*;

  tsq_line_if line ();

  tsq_state_t       state_r;
  logic [1:0]       phase_r;
  logic [2:0]       bitIdx_r;
  logic             owned_r;
  logic             addrPhase_r;
  logic             rxMode_r;
  logic             pendStart_r;
  logic             nack_r;
  logic             sdaOe_r;
  logic             sclOe_r;
  logic             driveLow_r;
  logic             busBusy_r;
  logic             sdaPrev_r;
  logic             sclPrev_r;
  logic             done_r;
  logic             ackEn_r;
  logic             beginReq_r;
  logic             haltReq_r;
  logic             wcol_r;
  logic             en_r;
  logic             irqEn_r;
  logic [7:0]       dataReg_r;
  logic [7:0]       statusCode_r;
  logic [DW-1:0]    readdata_r;
  logic             waitreq_r;
  logic             tick;
  logic             run;
  logic             adv;
  logic             accept;
  logic             wrCtrl;
  logic             wrData;
  logic             resume;
  logic             startFin;
  logic             ackFin;
  logic             stopFin;
  logic             arbLost;
  logic             doneSet;
  logic [7:0]       wd;
  logic [7:0]       statusNxt;
  logic [7:0]       ctrlRd;
  logic [7:0]       rdByte;

  tsq_line_sync u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sclRaw  (scl_i),
    .sdaRaw  (sda_i),
    .line    (line.src)
  );

  tsq_tick_gen #(.PERIOD(QUARTER)) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (run),
    .tick    (tick)
  );

  // Bus slave: every access sees waitrequest high for one cycle, then low for one.
  assign accept = (avs_read || avs_write) && !waitreq_r;
  assign wd     = avs_writedata[7:0];
  assign wrCtrl = accept && avs_write && (avs_address == OFS_CTRL);
  assign wrData = accept && avs_write && (avs_address == OFS_DATA);
  assign resume = wrCtrl && wd[CTL_DONE] && wd[CTL_EN] && done_r;

  always_comb begin
    ctrlRd            = '0;
    ctrlRd[CTL_DONE]  = done_r; // RULE23
    ctrlRd[CTL_ACKEN] = ackEn_r;
    ctrlRd[CTL_BEGIN] = beginReq_r;
    ctrlRd[CTL_HALT]  = haltReq_r;
    ctrlRd[CTL_WCOL]  = wcol_r;
    ctrlRd[CTL_EN]    = en_r;
    ctrlRd[CTL_IRQEN] = irqEn_r;
    case (avs_address)
      OFS_CTRL: rdByte = ctrlRd;
      OFS_STAT: rdByte = statusCode_r;
      OFS_DATA: rdByte = dataReg_r;
      default:  rdByte = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      waitreq_r  <= 1'b1;
      readdata_r <= '0;
    end else begin
      waitreq_r <= !((avs_read || avs_write) && waitreq_r);
      if (avs_read && waitreq_r) begin
        readdata_r <= DW'(rdByte);
      end
    end
  end

  // Bus activity of any master, seen through the synchroniser.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sdaPrev_r <= 1'b1;
      sclPrev_r <= 1'b1;
      busBusy_r <= 1'b0;
    end else begin
      sdaPrev_r <= line.sdaLvl;
      sclPrev_r <= line.sclLvl;
      if (line.sclLvl && sclPrev_r && sdaPrev_r && !line.sdaLvl) begin
        busBusy_r <= 1'b1;
      end else if (line.sclLvl && sclPrev_r && !sdaPrev_r && line.sdaLvl) begin
        busBusy_r <= 1'b0;
      end
    end
  end

  // A slave stretching the clock holds the sample phase until the line is high.
  assign run      = (state_r == S_START) || (state_r == S_BYTE) ||
                    (state_r == S_ACK) || (state_r == S_STOP);
  assign adv      = tick && !(phase_r == PH_SAMPLE && !line.sclLvl);
  assign startFin = (state_r == S_START) && adv && (phase_r == PH_LOW);
  assign ackFin   = (state_r == S_ACK) && adv && (phase_r == PH_LOW);
  assign stopFin  = (state_r == S_STOP) && adv && (phase_r == PH_LOW);
  assign arbLost  = (state_r == S_BYTE) && adv && (phase_r == PH_SAMPLE) &&
                    dataReg_r[bitIdx_r] && !line.sdaLvl; // RULE16
  assign doneSet  = startFin || ackFin || arbLost;

  always_comb begin
    statusNxt = ST_NO_INFO;
    if (startFin) begin
      statusNxt = owned_r ? ST_RESTART : ST_START; // RULE3 RULE11
    end else if (arbLost) begin
      statusNxt = ST_ARB_LOST; // RULE5
    end else if (ackFin && addrPhase_r && dataReg_r[DIR_BIT]) begin
      statusNxt = nack_r ? ST_RD_NACK : ST_RD_ACK; // RULE12
    end else if (ackFin && addrPhase_r) begin
      statusNxt = nack_r ? ST_ADDR_NACK : ST_ADDR_ACK; // RULE5
    end else if (ackFin) begin
      statusNxt = nack_r ? ST_DATA_NACK : ST_DATA_ACK; // RULE8
    end
  end

  // The set wins over a software clear arriving in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_r       <= 1'b0;
      statusCode_r <= ST_NO_INFO;
    end else if (doneSet) begin
      done_r       <= 1'b1;
      statusCode_r <= statusNxt;
    end else if (resume || (wrCtrl && !wd[CTL_EN])) begin
      done_r       <= 1'b0;
      statusCode_r <= ST_NO_INFO;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ackEn_r    <= 1'b0;
      beginReq_r <= 1'b0;
      en_r       <= 1'b0;
      irqEn_r    <= 1'b0;
    end else if (wrCtrl) begin
      ackEn_r    <= wd[CTL_ACKEN];
      beginReq_r <= wd[CTL_BEGIN];
      en_r       <= wd[CTL_EN];
      irqEn_r    <= wd[CTL_IRQEN];
    end
  end

  // A fresh halt request written in the same cycle as the STOP ends is kept.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      haltReq_r <= 1'b0;
    end else if (wrCtrl) begin
      haltReq_r <= wd[CTL_HALT];
    end else if (stopFin) begin
      haltReq_r <= 1'b0; // RULE14 RULE15
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dataReg_r <= '0;
      wcol_r    <= 1'b0;
    end else if (wrData && !done_r) begin
      wcol_r <= 1'b1; // RULE7
    end else if (wrData) begin
      dataReg_r <= wd; // RULE6
      wcol_r    <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nack_r <= 1'b1;
    end else if ((state_r == S_ACK) && adv && (phase_r == PH_SAMPLE)) begin
      nack_r <= line.sdaLvl;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r     <= S_IDLE;
      phase_r     <= PH_SETUP;
      bitIdx_r    <= BIT_MSB;
      owned_r     <= 1'b0;
      addrPhase_r <= 1'b0;
      rxMode_r    <= 1'b0;
      pendStart_r <= 1'b0;
      sdaOe_r     <= 1'b0;
      sclOe_r     <= 1'b0;
      driveLow_r  <= 1'b0;
    end else if (wrCtrl && !wd[CTL_EN]) begin
      state_r <= S_IDLE;
      owned_r <= 1'b0;
      sdaOe_r <= 1'b0;
      sclOe_r <= 1'b0;
    end else begin
      driveLow_r <= 1'b0;
      if (adv) begin
        phase_r <= phase_r + 2'h1;
      end
      case (state_r)
        S_IDLE: begin
          sdaOe_r <= 1'b0;
          sclOe_r <= 1'b0;
          if (wrCtrl && wd[CTL_BEGIN] && wd[CTL_EN]) begin
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          phase_r <= PH_SETUP;
          if (!busBusy_r) begin
            state_r <= S_START; // RULE2
          end
        end
        S_START: begin
          if (adv) begin
            case (phase_r)
              PH_SETUP:  sdaOe_r <= 1'b0;
              PH_HIGH:   sclOe_r <= 1'b0;
              PH_SAMPLE: sdaOe_r <= 1'b1;
              default: begin
                sclOe_r     <= 1'b1;
                owned_r     <= 1'b1; // RULE11
                addrPhase_r <= 1'b1;
                rxMode_r    <= 1'b0;
                state_r     <= S_HOLD;
              end
            endcase
          end
        end
        S_BYTE: begin
          if (adv) begin
            case (phase_r)
              PH_SETUP:  sdaOe_r <= !dataReg_r[bitIdx_r]; // RULE22
              PH_HIGH:   sclOe_r <= 1'b0;
              PH_SAMPLE: begin
                if (arbLost) begin
                  sdaOe_r <= 1'b0; // RULE16
                  sclOe_r <= 1'b0;
                  owned_r <= 1'b0;
                  state_r <= S_HOLD;
                end
              end
              default: begin
                sclOe_r  <= 1'b1;
                bitIdx_r <= bitIdx_r - 3'h1;
                if (bitIdx_r == BIT_LSB) begin
                  state_r <= S_ACK;
                end
              end
            endcase
          end
        end
        S_ACK: begin
          if (adv) begin
            case (phase_r)
              PH_SETUP:  sdaOe_r <= 1'b0;
              PH_HIGH:   sclOe_r <= 1'b0;
              PH_SAMPLE: sclOe_r <= 1'b0;
              default: begin
                sclOe_r     <= 1'b1; // RULE19
                addrPhase_r <= 1'b0;
                if (addrPhase_r) begin
                  rxMode_r <= dataReg_r[DIR_BIT]; // RULE12 RULE21
                end
                state_r <= S_HOLD;
              end
            endcase
          end
        end
        S_HOLD: begin
          phase_r  <= PH_SETUP;
          bitIdx_r <= BIT_MSB;
          if (resume) begin
            pendStart_r <= wd[CTL_BEGIN] && wd[CTL_HALT];
            if (!owned_r) begin
              state_r <= wd[CTL_BEGIN] ? S_WAIT : S_IDLE; // RULE16 RULE17
            end else if (wd[CTL_HALT]) begin
              state_r <= S_STOP; // RULE14 RULE15
            end else if (wd[CTL_BEGIN]) begin
              state_r <= S_START; // RULE13
            end else if (!rxMode_r) begin
              state_r <= S_BYTE; // RULE8
            end
          end
        end
        S_STOP: begin
          if (adv) begin
            case (phase_r)
              PH_SETUP:  sdaOe_r <= 1'b1;
              PH_HIGH:   sclOe_r <= 1'b0;
              PH_SAMPLE: sdaOe_r <= 1'b0;
              default: begin
                owned_r  <= 1'b0;
                rxMode_r <= 1'b0;
                state_r  <= pendStart_r ? S_WAIT : S_IDLE; // RULE15
              end
            endcase
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitreq_r;
  assign scl_o           = driveLow_r;
  assign sda_o           = driveLow_r;
  assign scl_oe          = sclOe_r;
  assign sda_oe          = sdaOe_r;

  a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
    ((avs_read || avs_write) && waitreq_r) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus access not answered after one wait cycle.");

  a_wait_free: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
    (state_r == S_WAIT && busBusy_r) |=> (state_r == S_WAIT || state_r == S_IDLE))
    else $error("START begun while the bus was busy.");

  a_start_code: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
    startFin |=> done_r && statusCode_r == ($past(owned_r) ? ST_RESTART : ST_START))
    else $error("Wrong status after START.");

  a_addr_code: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    (ackFin && addrPhase_r && !dataReg_r[DIR_BIT])
    |=> done_r && statusCode_r == ($past(nack_r) ? ST_ADDR_NACK : ST_ADDR_ACK))
    else $error("Wrong status after address.");

  a_data_code: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
    (ackFin && !addrPhase_r)
    |=> done_r && statusCode_r == ($past(nack_r) ? ST_DATA_NACK : ST_DATA_ACK))
    else $error("Wrong status after data byte.");

  a_wcol_flag: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
    (wrData && !done_r) |=> wcol_r && $stable(dataReg_r))
    else $error("Colliding data write not rejected.");

  a_halt_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
    (stopFin && !wrCtrl) |=> !haltReq_r)
    else $error("Halt request not cleared after STOP.");

  a_stop_start: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    (stopFin && pendStart_r && !wrCtrl) |=> state_r == S_WAIT ##1 state_r != S_HOLD)
    else $error("No START queued after STOP.");

  a_arb_release: assert property (@(posedge sys_clk) disable iff (rst) // RULE16
    arbLost |=> done_r && !sdaOe_r && !sclOe_r && statusCode_r == ST_ARB_LOST)
    else $error("Bus not released on lost arbitration.");

  a_arb_idle: assert property (@(posedge sys_clk) disable iff (rst) // RULE16
    (state_r == S_HOLD && !owned_r && resume && !wd[CTL_BEGIN]) |=> state_r == S_IDLE)
    else $error("Lost arbitration did not return to idle.");

  a_hold_bus: assert property (@(posedge sys_clk) disable iff (rst) // RULE19
    (state_r == S_HOLD && owned_r && done_r) |-> sclOe_r && !run)
    else $error("Clock not held low while done is set.");

  a_dir_bit: assert property (@(posedge sys_clk) disable iff (rst) // RULE22
    (state_r == S_BYTE && addrPhase_r && bitIdx_r == BIT_LSB && phase_r == PH_SAMPLE)
    |-> sdaOe_r == !dataReg_r[DIR_BIT])
    else $error("Direction bit driven wrongly.");

endmodule

// ---- tb/tsq_slave_model.sv ----
`timescale 1ns/1ps
module tsq_slave_model (
  input  wire logic       sclWire,
  input  wire logic       sdaWire,
  input  wire logic       ackEn,
  input  wire logic       stretchEn,
  input  wire logic       arbGrab,
  output logic            sclOe,
  output logic            sdaOe,
  output logic [7:0]      lastByte,
  output logic [7:0]      byteCount,
  output logic [7:0]      startCount,
  output logic [7:0]      stopCount
);
  int         bitCnt;
  logic [7:0] shiftReg;
  logic       ackDrive;

  initial begin
    sclOe = 1'b0;
    ackDrive = 1'b0;
    bitCnt = -1;
    shiftReg = 8'h00;
    lastByte = 8'h00;
    byteCount = 8'h00;
    startCount = 8'h00;
    stopCount = 8'h00;
  end

  // Grabbing the first bit of every byte makes a master sending a one there lose arbitration.
  assign sdaOe = ackDrive | (arbGrab & (bitCnt == 0));

  always @(negedge sdaWire) begin
    if (sclWire) begin
      startCount <= startCount + 8'h01;
      bitCnt <= -1;
      ackDrive <= 1'b0;
    end
  end

  always @(posedge sdaWire) begin
    if (sclWire) begin
      stopCount <= stopCount + 8'h01;
      bitCnt <= -1;
    end
  end

  always @(posedge sclWire) begin
    if (bitCnt >= 0 && bitCnt < 8) begin
      shiftReg <= {shiftReg[6:0], sdaWire};
    end
  end

  // Bits are counted on the falling clock, so the count is still valid while the master samples.
  always @(negedge sclWire) begin
    if (bitCnt == 7) begin
      lastByte <= shiftReg;
      byteCount <= byteCount + 8'h01;
      ackDrive <= ackEn;
      bitCnt <= 8;
    end else if (bitCnt == 8) begin
      ackDrive <= 1'b0;
      bitCnt <= 0;
    end else begin
      bitCnt <= bitCnt + 1;
    end
  end

  // A slow slave holds the clock low after every falling edge.
  always @(negedge sclWire) begin
    if (stretchEn) begin
      sclOe <= 1'b1;
      #60;
      sclOe <= 1'b0;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import tsq_pkg::*;
  localparam logic [7:0] C_START = 8'hA4;
  localparam logic [7:0] C_GO    = 8'h84;
  localparam logic [7:0] C_STOP  = 8'h94;
  localparam logic [7:0] C_BOTH  = 8'hB4;
  logic          sys_clk;
  logic          rst;
  logic [AW-1:0] avsAddress;
  logic          avsRead;
  logic          avsWrite;
  logic [DW-1:0] avsWritedata;
  logic [DW-1:0] avsReaddata;
  logic          avsWaitrequest;
  logic          uutSclOe;
  logic          uutSdaOe;
  logic          uutSclO;
  logic          uutSdaO;
  logic          slvSclOe;
  logic          slvSdaOe;
  logic          ackEn;
  logic          stretchEn;
  logic          arbGrab;
  logic [7:0]    lastByte;
  logic [7:0]    byteCount;
  logic [7:0]    startCount;
  logic [7:0]    stopCount;
  wire           sclWire = !(uutSclOe && !uutSclO) && !slvSclOe;
  wire           sdaWire = !(uutSdaOe && !uutSdaO) && !slvSdaOe;
  int            miscompares;
  int            checkCount;

  tsq_master_tx uut (.sys_clk(sys_clk), .rst(rst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .scl_i(sclWire),
    .scl_o(uutSclO), .scl_oe(uutSclOe), .sda_i(sdaWire), .sda_o(uutSdaO),
    .sda_oe(uutSdaOe));

  tsq_slave_model slv (.sclWire(sclWire), .sdaWire(sdaWire), .ackEn(ackEn),
    .stretchEn(stretchEn), .arbGrab(arbGrab), .sclOe(slvSclOe), .sdaOe(slvSdaOe),
    .lastByte(lastByte), .byteCount(byteCount), .startCount(startCount),
    .stopCount(stopCount));

  always #2 sys_clk = ~sys_clk;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic avXfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata[7:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (!wr) chk8(avsReaddata[15:8] | avsReaddata[23:16] | avsReaddata[31:24], 8'h00);
  endtask

  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    avXfer(1'b1, a, d, q);
  endtask

  task automatic rdReg(input logic [3:0] a, output logic [7:0] q);
    avXfer(1'b0, a, 8'h00, q);
  endtask

  // Polls one control bit; a bound keeps a stuck flag from hanging the run.
  task automatic waitBit(input int b, input logic v);
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      rdReg(OFS_CTRL, q);
      n++;
    end while (q[b] !== v && n < 3000);
    chk8({7'h00, q[b]}, {7'h00, v});
  endtask

  task automatic step(input logic [7:0] ctl, input logic [7:0] st);
    logic [7:0] q;
    wrReg(OFS_CTRL, ctl);
    waitBit(CTL_DONE, 1'b1);
    rdReg(OFS_STAT, q);
    chk8(q, st);
  endtask

  task automatic stopSeq();
    logic [7:0] q;
    logic [7:0] p;
    p = stopCount;
    wrReg(OFS_CTRL, C_STOP);
    waitBit(CTL_HALT, 1'b0);
    chk8(stopCount, p + 8'h01);
    rdReg(OFS_STAT, q);
    chk8(q & 8'hF8, ST_NO_INFO);
  endtask

  task automatic tRegs();
    logic [7:0] q;
    rdReg(OFS_CTRL, q);
    chk8(q, 8'h00);
    rdReg(OFS_STAT, q);
    chk8(q, ST_NO_INFO);
    rdReg(OFS_DATA, q);
    chk8(q, 8'h00);
    wrReg(OFS_STAT, 8'h55);
    rdReg(OFS_STAT, q);
    chk8(q, ST_NO_INFO);
    wrReg(4'hC, 8'hFF);
    rdReg(4'hC, q);
    chk8(q, 8'h00);
    wrReg(OFS_CTRL, 8'h43);
    rdReg(OFS_CTRL, q);
    chk8(q, 8'h41);
    wrReg(OFS_CTRL, 8'h00);
    $display("test registers done");
  endtask

  task automatic tWriteAck();
    logic [7:0] q;
    logic [7:0] s;
    logic [7:0] b;
    s = startCount;
    step(C_START, ST_START);
    chk8(startCount, s + 8'h01);
    wrReg(OFS_DATA, 8'hA0);
    wrReg(OFS_CTRL, C_GO);
    wrReg(OFS_DATA, 8'hEE);
    rdReg(OFS_CTRL, q);
    chk8({7'h00, q[CTL_WCOL]}, 8'h01);
    waitBit(CTL_DONE, 1'b1);
    rdReg(OFS_STAT, q);
    chk8(q, ST_ADDR_ACK);
    chk8(lastByte, 8'hA0);
    b = byteCount;
    repeat (40) @(posedge sys_clk);
    chk8({7'h00, uutSclOe}, 8'h01);
    chk8(byteCount, b);
    stretchEn <= 1'b1;
    wrReg(OFS_DATA, 8'h5C);
    rdReg(OFS_CTRL, q);
    chk8({7'h00, q[CTL_WCOL]}, 8'h00);
    step(C_GO, ST_DATA_ACK);
    chk8(lastByte, 8'h5C);
    stretchEn <= 1'b0;
    stopSeq();
    $display("test write with ack done");
  endtask

  task automatic tNackRestart();
    logic [7:0] q;
    logic [7:0] s;
    logic [7:0] p;
    ackEn <= 1'b0;
    step(C_START, ST_START);
    wrReg(OFS_DATA, 8'hB0);
    step(C_GO, ST_ADDR_NACK);
    wrReg(OFS_DATA, 8'h33);
    step(C_GO, ST_DATA_NACK);
    s = startCount;
    p = stopCount;
    step(C_START, ST_RESTART);
    chk8(stopCount, p);
    chk8(startCount, s + 8'h01);
    ackEn <= 1'b1;
    wrReg(OFS_DATA, 8'hB1);
    step(C_GO, ST_RD_ACK);
    chk8(lastByte, 8'hB1);
    step(C_BOTH, ST_START);
    rdReg(OFS_CTRL, q);
    chk8({7'h00, q[CTL_HALT]}, 8'h00);
    chk8(stopCount, p + 8'h01);
    chk8(startCount, s + 8'h02);
    stopSeq();
    $display("test nack and restart done");
  endtask

  task automatic tArbLost();
    logic [7:0] q;
    logic [7:0] s;
    arbGrab <= 1'b1;
    step(C_START, ST_START);
    wrReg(OFS_DATA, 8'hC0);
    step(C_GO, ST_ARB_LOST);
    s = startCount;
    wrReg(OFS_CTRL, C_GO);
    arbGrab <= 1'b0;
    repeat (100) @(posedge sys_clk);
    rdReg(OFS_CTRL, q);
    chk8({7'h00, q[CTL_DONE]}, 8'h00);
    chk8(startCount, s);
    arbGrab <= 1'b1;
    step(C_START, ST_START);
    wrReg(OFS_DATA, 8'hC0);
    step(C_GO, ST_ARB_LOST);
    s = startCount;
    wrReg(OFS_CTRL, C_START);
    repeat (100) @(posedge sys_clk);
    rdReg(OFS_CTRL, q);
    chk8({7'h00, q[CTL_DONE]}, 8'h00);
    chk8(startCount, s);
    arbGrab <= 1'b0;
    waitBit(CTL_DONE, 1'b1);
    rdReg(OFS_STAT, q);
    chk8(q, ST_START);
    chk8(startCount, s + 8'h01);
    stopSeq();
    $display("test lost arbitration done");
  endtask

  task automatic finalReport();
    $display("checks=%0d mismatches=%0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h00000000;
    ackEn = 1'b1;
    stretchEn = 1'b0;
    arbGrab = 1'b0;
    miscompares = 0;
    checkCount = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    tRegs();
    tWriteAck();
    tNackRestart();
    tArbLost();
    finalReport();
  end

  // The whole sequence needs some thirteen hundred cycles; this bound leaves ample margin.
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    finalReport();
  end
endmodule
